/* light_readout_pkg.sv */
package light_readout_pkg;

	localparam int RESULT_W = 20;
	localparam int PERSIST_W = 4;
	localparam int PERSIST_CNT_W = 5;

	localparam logic [7:0] ADDR_SENSOR_STATUS = 8'h07;
	localparam logic [7:0] ADDR_AMBIENT_LOW = 8'h0d;
	localparam logic [7:0] ADDR_AMBIENT_MID = 8'h0e;
	localparam logic [7:0] ADDR_AMBIENT_HIGH = 8'h0f;
	localparam logic [7:0] ADDR_UV_LOW = 8'h10;
	localparam logic [7:0] ADDR_UV_MID = 8'h11;
	localparam logic [7:0] ADDR_UV_HIGH = 8'h12;
	localparam logic [7:0] ADDR_FREEZE_FIRST = 8'h07;
	localparam logic [7:0] ADDR_FREEZE_LAST = 8'h12;

	localparam int STATUS_POWER_ON_BIT = 5;
	localparam int STATUS_INT_BIT = 4;
	localparam int STATUS_NEW_DATA_BIT = 3;
	localparam logic [7:0] STATUS_RESET = 8'h20;
	localparam logic [7:0] RESULT_BYTE_RESET = 8'h00;
	localparam logic [RESULT_W-1:0] RESULT_RESET = 20'h00000;
	localparam logic [PERSIST_CNT_W-1:0] PERSIST_CNT_RESET = 5'h00;
	localparam logic [PERSIST_CNT_W-1:0] PERSIST_CNT_MAX = 5'h10;

	// Source select codes; bit 1 high picks the ultraviolet channel
	localparam logic [1:0] SRC_AMBIENT = 2'h1;
	localparam logic [1:0] SRC_ULTRAVIOLET = 2'h3;

	typedef struct packed {
		logic [RESULT_W-1:0] ambient;
		logic [RESULT_W-1:0] ultraviolet;
	} result_pair_t;

	typedef struct packed {
		logic power_on;
		logic int_flag;
		logic data_new;
	} status_flags_t;

	typedef struct packed {
		logic [RESULT_W-1:0] upper;
		logic [RESULT_W-1:0] lower;
		logic [PERSIST_W-1:0] persistence_count;
		logic [1:0] threshold_source_select;
		logic enable;
	} threshold_cfg_t;

endpackage

/* out_of_range_persist.sv */
`timescale 1ns/1ps
module out_of_range_persist
	import light_readout_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic sample_i,
	input wire logic out_of_range_i,
	input wire logic restart_i,
	input wire logic [PERSIST_W-1:0] persistence_count_i,
	output logic hit_o
);

	logic [PERSIST_CNT_W-1:0] run_len;
	logic reached;

	assign reached = run_len >= {1'b0, persistence_count_i};

	// Consecutive out-of-range run, saturating at sixteen
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			run_len <= PERSIST_CNT_RESET;
		end else if (restart_i) begin
			run_len <= PERSIST_CNT_RESET;
		end else if (sample_i) begin
			if (!out_of_range_i) begin
				run_len <= PERSIST_CNT_RESET;
			end else if (run_len != PERSIST_CNT_MAX) begin
				run_len <= run_len + 5'h01;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hit_o <= 1'b0;
		end else begin
			hit_o <= sample_i && out_of_range_i && reached && !restart_i;
		end
	end

	AST_PERSIST_HIT: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		sample_i && out_of_range_i && !restart_i && (run_len >= {1'b0, persistence_count_i})
		|=> hit_o)
		else $error("persistence run reached but no hit");

	AST_PERSIST_NO_EARLY: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		sample_i && (run_len < {1'b0, persistence_count_i}) |=> !hit_o)
		else $error("hit before persistence count reached");

endmodule

/* light_result_status_readout.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Status byte at 0x07 is read-only and resets to 0x20.
// - Power-on flag, bit 5, is set by power-on reset.
// - Power-on flag clears once the host reads the status byte.
// - Interrupt flag, bit 4, sets after persistent out-of-threshold results.
// - Interrupt flag resets to 0 and clears after a status read.
// - New-data flag, bit 3, sets on fresh result, clears on status read.
// - Ambient result: 20 bits at 0x0D, 0x0E, low nibble of 0x0F.
// - Ultraviolet result: 20 bits at 0x10, 0x11, low nibble of 0x12.
// - Results freeze while a host read addresses 0x07 to 0x12.
// - Freeze ends when the read ends or leaves that range.
// - Measurements finishing during a freeze go into shadow registers.
// - Shadow results copy to visible results once no protected read runs.
// - Result bytes reset to zero; top nibbles of high bytes read zero.
// - A main control write aborts and restarts measurement.
// - Persistence value plus one consecutive out-of-range results are needed.
// - Threshold compare uses ambient or ultraviolet result per source select.
module light_result_status_readout
	import light_readout_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic rd_active_i,
	input wire logic [7:0] rd_addr_i,
	input wire logic rd_done_i,
	output logic [7:0] rd_data_o,
	input wire logic ctrl_write_i,
	output logic meas_restart_o,
	input wire logic meas_done_i,
	input wire result_pair_t meas_result_i,
	input wire threshold_cfg_t thresh_cfg_i,
	output logic [7:0] sensor_status_o,
	output logic int_flag_o
);

	status_flags_t flags;
	result_pair_t results;
	result_pair_t shadow;
	logic pending;
	logic frozen;
	logic status_read;
	logic result_update;
	logic [RESULT_W-1:0] compare_value;
	logic out_of_range;
	logic int_hit;
	logic restart_seen;

	function automatic logic in_freeze_range(input logic [7:0] addr);
		return (addr >= ADDR_FREEZE_FIRST) && (addr <= ADDR_FREEZE_LAST);
	endfunction

	function automatic logic [7:0] status_byte(input status_flags_t f);
		logic [7:0] b;
		b = 8'h00;
		b[STATUS_POWER_ON_BIT] = f.power_on;
		b[STATUS_INT_BIT] = f.int_flag;
		b[STATUS_NEW_DATA_BIT] = f.data_new;
		return b;
	endfunction

	function automatic logic [7:0] read_byte(input logic [7:0] addr, input status_flags_t f,
			input result_pair_t r);
		logic [7:0] b;
		b = 8'h00;
		unique case (addr)
			ADDR_SENSOR_STATUS: b = status_byte(f);
			ADDR_AMBIENT_LOW: b = r.ambient[7:0];
			ADDR_AMBIENT_MID: b = r.ambient[15:8];
			ADDR_AMBIENT_HIGH: b = {4'h0, r.ambient[19:16]};
			ADDR_UV_LOW: b = r.ultraviolet[7:0];
			ADDR_UV_MID: b = r.ultraviolet[15:8];
			ADDR_UV_HIGH: b = {4'h0, r.ultraviolet[19:16]};
			default: b = 8'h00;
		endcase
		return b;
	endfunction

	// Freeze follows the live read window, so it drops the cycle the read ends
	assign frozen = rd_active_i && in_freeze_range(rd_addr_i);
	assign status_read = rd_done_i && (rd_addr_i == ADDR_SENSOR_STATUS);
	assign result_update = !frozen && (meas_done_i || pending);

	// Compare source: bit 1 of the select picks ultraviolet
	assign compare_value = thresh_cfg_i.threshold_source_select[1] ?
		meas_result_i.ultraviolet : meas_result_i.ambient;
	assign out_of_range = (compare_value > thresh_cfg_i.upper) ||
		(compare_value < thresh_cfg_i.lower);

	out_of_range_persist u_persist (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.sample_i(meas_done_i && thresh_cfg_i.enable && !restart_seen),
		.out_of_range_i(out_of_range),
		.restart_i(ctrl_write_i),
		.persistence_count_i(thresh_cfg_i.persistence_count),
		.hit_o(int_hit)
	);

	// Measurement restart after a control write
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meas_restart_o <= 1'b0;
		end else begin
			meas_restart_o <= ctrl_write_i;
		end
	end

	// Ignore a completion racing the restart; it belongs to the aborted run
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			restart_seen <= 1'b0;
		end else begin
			restart_seen <= ctrl_write_i;
		end
	end

	// Shadow staging during a freeze
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			shadow <= {RESULT_RESET, RESULT_RESET};
		end else if (meas_done_i && frozen && !restart_seen) begin
			shadow <= meas_result_i;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pending <= 1'b0;
		end else if (meas_done_i && frozen && !restart_seen) begin
			pending <= 1'b1;
		end else if (!frozen) begin
			pending <= 1'b0;
		end
	end

	// Host-visible results
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			results <= {RESULT_RESET, RESULT_RESET};
		end else if (!frozen) begin
			if (meas_done_i && !restart_seen) begin
				results <= meas_result_i;
			end else if (pending) begin
				results <= shadow;
			end
		end
	end

	// Status flags; a setting event beats a clearing read
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			flags.power_on <= 1'b1;
		end else if (status_read) begin
			flags.power_on <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			flags.int_flag <= 1'b0;
		end else if (int_hit) begin
			flags.int_flag <= 1'b1;
		end else if (status_read) begin
			flags.int_flag <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			flags.data_new <= 1'b0;
		end else if (result_update && !(meas_done_i && restart_seen && !pending)) begin
			flags.data_new <= 1'b1;
		end else if (status_read) begin
			flags.data_new <= 1'b0;
		end
	end

	// Read data tracks the address one cycle later, using pre-clear flags
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rd_data_o <= RESULT_BYTE_RESET;
		end else begin
			rd_data_o <= read_byte(rd_addr_i, flags, results);
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sensor_status_o <= STATUS_RESET;
		end else begin
			sensor_status_o <= status_byte(flags);
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			int_flag_o <= 1'b0;
		end else begin
			int_flag_o <= flags.int_flag;
		end
	end

	sequence s_status_read;
		rd_done_i && (rd_addr_i == ADDR_SENSOR_STATUS);
	endsequence

	sequence s_frozen_finish;
		frozen && meas_done_i && !restart_seen;
	endsequence

	AST_STATUS_VALUE: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		rd_addr_i == ADDR_SENSOR_STATUS |=> rd_data_o == status_byte($past(flags)))
		else $error("status byte differs from flags");

	AST_POWER_ON_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		s_status_read |=> !flags.power_on ##1 !flags.power_on)
		else $error("power-on flag not cleared by status read");

	AST_INT_SET: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		int_hit |=> flags.int_flag ##1 int_flag_o)
		else $error("interrupt flag not set after hit");

	AST_INT_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		s_status_read ##0 !int_hit |=> !flags.int_flag)
		else $error("interrupt flag not cleared by status read");

	AST_NEW_DATA: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		!frozen && meas_done_i && !restart_seen |=> flags.data_new &&
		results == $past(meas_result_i))
		else $error("fresh result not flagged or not stored");

	AST_FREEZE_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		frozen |=> $stable(results))
		else $error("results changed during protected read");

	AST_SHADOW_STAGE: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		s_frozen_finish |=> pending && shadow == $past(meas_result_i))
		else $error("frozen measurement not staged");

	AST_SHADOW_COPY: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		pending && !frozen && !meas_done_i |=> results == $past(shadow) && !pending)
		else $error("staged result not copied after release");

	AST_HIGH_NIBBLE_ZERO: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(rd_addr_i == ADDR_AMBIENT_HIGH) || (rd_addr_i == ADDR_UV_HIGH)
		|=> rd_data_o[7:4] == 4'h0)
		else $error("reserved nibble of high byte not zero");

	AST_RESTART: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		ctrl_write_i ##1 !ctrl_write_i |-> meas_restart_o ##1 !meas_restart_o)
		else $error("restart pulse wrong after control write");

	sequence s_stale_finish;
		restart_seen && meas_done_i && !pending;
	endsequence

	AST_RESTART_DISCARD: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		s_stale_finish |=> $stable(results))
		else $error("completion of aborted run was stored");

	AST_INT_OUT_COPY: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		1'b1 |=> int_flag_o == $past(flags.int_flag))
		else $error("interrupt output does not follow flag");

	AST_STATUS_COPY: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		1'b1 |=> sensor_status_o == status_byte($past(flags)))
		else $error("status output does not follow flags");

	AST_DATA_NEW_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		s_status_read ##0 !result_update |=> !flags.data_new)
		else $error("new-data flag not cleared by status read");

	AST_PENDING_DROP: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		!frozen |=> !pending)
		else $error("staged result left pending after release");

	AST_UNMAPPED_ZERO: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		rd_addr_i > ADDR_UV_HIGH |=> rd_data_o == 8'h00)
		else $error("unmapped address read not zero");

	AST_STATUS_RESERVED: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		rd_addr_i == ADDR_SENSOR_STATUS |=> rd_data_o[7:6] == 2'h0 && rd_data_o[2:0] == 3'h0)
		else $error("reserved status bits not zero");

	AST_POWER_ON_STAYS: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		!flags.power_on |=> !flags.power_on)
		else $error("power-on flag set again after clearing");

endmodule

/* light_host_model.sv */
`timescale 1ns/1ps
module light_host_model
	import light_readout_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic [7:0] rd_data_i,
	output logic rd_active_o,
	output logic [7:0] rd_addr_o,
	output logic rd_done_o
);
	initial begin
		rd_active_o = 1'b0;
		rd_addr_o = 8'h00;
		rd_done_o = 1'b0;
	end
	// Call just after a rising edge; address held through the done pulse
	task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
		rd_active_o = 1'b1;
		rd_addr_o = a;
		@(posedge ref_clk_i);
		#1;
		d = rd_data_i;
		rd_done_o = 1'b1;
		@(posedge ref_clk_i);
		#1;
		rd_done_o = 1'b0;
	endtask
	// Released address shows the inverse of its last value
	task automatic stop();
		rd_active_o = 1'b0;
		rd_addr_o = ~rd_addr_o;
	endtask
endmodule

/* light_result_status_readout_bench.sv */
`timescale 1ns/1ps
module light_result_status_readout_bench;
	import light_readout_pkg::*;
	logic ref_clk_i, rstn_i, rd_active, rd_done, ctrl_write_i, meas_restart_o;
	logic meas_done_i, int_flag_o;
	logic [7:0] rd_addr, rd_data_o, sensor_status_o;
	result_pair_t meas_result_i;
	threshold_cfg_t thresh_cfg_i;
	int miscompares = 0;
	int n_checks = 0;

	light_result_status_readout i_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
		.rd_active_i(rd_active), .rd_addr_i(rd_addr), .rd_done_i(rd_done),
		.rd_data_o(rd_data_o), .ctrl_write_i(ctrl_write_i), .meas_restart_o(meas_restart_o),
		.meas_done_i(meas_done_i), .meas_result_i(meas_result_i),
		.thresh_cfg_i(thresh_cfg_i), .sensor_status_o(sensor_status_o),
		.int_flag_o(int_flag_o));
	light_host_model i_host (.ref_clk_i(ref_clk_i), .rd_data_i(rd_data_o),
		.rd_active_o(rd_active), .rd_addr_o(rd_addr), .rd_done_o(rd_done));

	initial begin
		ref_clk_i = 1'b0;
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		i_host.read_byte(a, d);
		chk($sformatf("reg %h", a), e, d);
	endtask

	task automatic rd_res(input logic [19:0] amb, input logic [19:0] uv);
		logic [7:0] e [6];
		e = '{amb[7:0], amb[15:8], {4'h0, amb[19:16]}, uv[7:0], uv[15:8], {4'h0, uv[19:16]}};
		for (int i = 0; i < 6; i++) begin
			rd(ADDR_AMBIENT_LOW + 8'(i), e[i]);
		end
	endtask

	task automatic meas(input logic [19:0] amb, input logic [19:0] uv);
		meas_result_i = '{ambient: amb, ultraviolet: uv};
		meas_done_i = 1'b1;
		cyc(1);
		meas_done_i = 1'b0;
		cyc(1);
	endtask

	task automatic t_reset();
		chk("status", 8'h20, sensor_status_o);
		chk("int", 8'h00, {7'h00, int_flag_o});
		rd(ADDR_SENSOR_STATUS, 8'h20);
		rd_res(20'h00000, 20'h00000);
		rd(8'h13, 8'h00);
		i_host.stop();
		cyc(2);
		chk("status", 8'h00, sensor_status_o);
	endtask

	task automatic t_new_and_freeze();
		meas(20'habcde, 20'h13579);
		chk("status", 8'h08, sensor_status_o);
		rd_res(20'habcde, 20'h13579);
		rd(ADDR_SENSOR_STATUS, 8'h08);
		i_host.stop();
		cyc(2);
		chk("status", 8'h00, sensor_status_o);
		rd(ADDR_AMBIENT_LOW, 8'hde);
		meas(20'h11111, 20'h22222);
		rd(ADDR_AMBIENT_MID, 8'hbc);
		rd(ADDR_UV_HIGH, 8'h01);
		i_host.stop();
		cyc(2);
		rd_res(20'h11111, 20'h22222);
		meas(20'h33333, 20'h44444);
		rd(8'h13, 8'h00);
		rd(ADDR_AMBIENT_LOW, 8'h33);
		rd(ADDR_SENSOR_STATUS, 8'h08);
		i_host.stop();
	endtask

	task automatic t_int();
		thresh_cfg_i = '{upper: 20'h00100, lower: 20'h00010, persistence_count: 4'h2,
			threshold_source_select: SRC_AMBIENT, enable: 1'b1};
		meas(20'h00200, 20'h00000);
		meas(20'h00005, 20'h00000);
		cyc(3);
		chk("int", 8'h00, {7'h00, int_flag_o});
		meas(20'h00200, 20'h00000);
		cyc(3);
		chk("int", 8'h01, {7'h00, int_flag_o});
		rd(ADDR_SENSOR_STATUS, 8'h18);
		i_host.stop();
		cyc(3);
		chk("int", 8'h00, {7'h00, int_flag_o});
		thresh_cfg_i.persistence_count = 4'h0;
		thresh_cfg_i.threshold_source_select = SRC_ULTRAVIOLET;
		meas(20'h00050, 20'h00005);
		cyc(3);
		chk("int", 8'h01, {7'h00, int_flag_o});
		rd(ADDR_SENSOR_STATUS, 8'h18);
		i_host.stop();
		thresh_cfg_i.persistence_count = 4'h1;
		thresh_cfg_i.threshold_source_select = SRC_AMBIENT;
		meas(20'h00050, 20'h00000);
		meas(20'h00200, 20'h00000);
		meas(20'h00050, 20'h00000);
		meas(20'h00200, 20'h00000);
		cyc(3);
		chk("int", 8'h00, {7'h00, int_flag_o});
		ctrl_write_i = 1'b1;
		cyc(1);
		ctrl_write_i = 1'b0;
		chk("restart", 8'h01, {7'h00, meas_restart_o});
		cyc(1);
		chk("restart", 8'h00, {7'h00, meas_restart_o});
		meas(20'h00200, 20'h00000);
		cyc(3);
		chk("int", 8'h00, {7'h00, int_flag_o});
		meas(20'h00200, 20'h00000);
		cyc(3);
		chk("int", 8'h01, {7'h00, int_flag_o});
	endtask

	initial begin
		rstn_i = 1'b0;
		ctrl_write_i = 1'b0;
		meas_done_i = 1'b0;
		meas_result_i = '0;
		thresh_cfg_i = '0;
		repeat (5) @(posedge ref_clk_i);
		#1;
		rstn_i = 1'b1;
		cyc(1);
		t_reset();
		t_new_and_freeze();
		t_int();
		end_sim();
	end

	// Watchdog against a hung run
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		miscompares++;
		end_sim();
	end
endmodule
